// file: dv/dfc_capture_tb.sv
// Self-checking bench for the DDR frame input capture block.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module dfc_capture_tb
   import dfc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic             clk, nrst, gate, dsync, rev, four, rsel, seln, sdrv, sdout, ready;
   logic             rv, mk, valid, sdo, sdoe, seloe, refen, tick, ovf;
   logic             took = 1'b0;
   logic [BUS_W-1:0] rb, fb;
   dfc_out_t         da, db;
   dfc_pair_t        exp_q[$];
   dfc_pair_t        e;
   int               failures = 0, n_tests = 0, cycles = 0, since = 0, quiet = 0, l1, l2;

   dfc_capture #(.DIV_W(4)) uut (.i_clk(clk), .i_nrst(nrst), .i_ddr_rise_valid(rv),
      .i_ddr_rise_byte(rb), .i_ddr_fall_byte(fb), .i_burst_marker(mk),
      .i_transmit_gate(gate), .i_divider_sync(dsync), .i_bus_reverse(rev),
      .i_four_pin_mode(four), .i_reference_select(rsel), .i_serial_select_n(seln),
      .i_serial_data_drive(sdrv), .i_serial_data_out(sdout), .i_sink_ready(ready),
      .o_sink_valid(valid), .o_chan_a_drive(da), .o_chan_b_drive(db),
      .o_serial_data_o(sdo), .o_serial_data_oe(sdoe), .o_serial_select_oe(seloe),
      .o_reference_out_en(refen), .o_div_tick(tick), .o_overflow(ovf));

   dfc_host_model host (.o_valid(rv), .o_rise(rb), .o_fall(fb), .o_marker(mk), .i_clk(clk));

   // Free-running 125 MHz clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Mirrors the bit order within each byte.
   function automatic logic [15:0] flip(input logic [15:0] v);
      for (int i = 0; i < 16; i++)
         flip[i] = v[i < 8 ? 7 - i : 23 - i];
   endfunction

   // Sends a random frame and notes the expected pair when the gate is open.
   task automatic frame();
      dfc_pair_t p;
      dfc_pair_t s;
      p.chan_a = 16'($urandom());
      p.chan_b = 16'($urandom());
      s.chan_a = rev ? flip(p.chan_a) : p.chan_a;
      s.chan_b = rev ? flip(p.chan_b) : p.chan_b;
      if (gate)
         exp_q.push_back(p);
      host.send_frame(s);
      repeat (8) @(negedge clk);
   endtask

   // Raises the strobe and measures the cycles to the next divider tick.
   task automatic sync_lat(output int l);
      dsync = 1'b1;
      l = 0;
      repeat (5) @(negedge clk);
      while (tick !== 1'b1 && l < 12) begin
         @(negedge clk);
         l++;
      end
      dsync = 1'b0;
      @(negedge clk);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Notes consumption, checks the divider period and cuts a hang short.
   always @(posedge clk) begin
      took <= valid && ready && nrst;
      cycles <= cycles + 1;
      quiet <= (!nrst || dsync) ? 0 : (quiet < 20 ? quiet + 1 : quiet);
      if (!nrst)
         since <= 0;
      else if (tick)
         since <= 1;
      else if (since > 0)
         since <= since + 1;
      if (tick && quiet == 20 && since > 0)
         `CHK(since, int'(DIV_LAST) + 1)
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end

   // Compares each consumed pair with the oldest noted one.
   always @(negedge clk) begin
      if (took && exp_q.size() == 0) begin
         failures++;
         $display("[FAIL] %0t pair not expected", $time);
      end else if (took) begin
         e = exp_q.pop_front();
         `CHK(da, {~e.chan_a, e.chan_a})
         `CHK(db, {~e.chan_b, e.chan_b})
      end
   end

   // Main sequence of scenarios.
   initial begin
      void'($urandom(91848));
      {nrst, gate, dsync, rev, four, rsel, seln, sdrv, sdout, ready} = '0;
      repeat (6) @(negedge clk);
      `CHK({da, db, valid, tick, ovf}, {32'hFFFF0000, 32'hFFFF0000, 3'h0})
      {nrst, gate, ready} = 3'h7;
      // Pin roles of the serial port and the reference pin.
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         {seln, four, rsel, sdrv} = i[3:0];
         sdout = 1'($urandom());
         #1;
         `CHK(sdoe, sdrv & ~four & ~seln)
         `CHK({seloe, refen, sdo}, {1'b0, ~rsel, sdout})
      end
      // Streaming with both bit orders.
      for (int i = 0; i < 8; i++) begin
         rev = i[0];
         frame();
      end
      // A stray unmarked pair yields nothing.
      host.send_pair(1'b0, 8'h5A, 8'hA5);
      repeat (8) @(negedge clk);
      // Stalled receiver: the next marker drops the waiting frame.
      ready = 1'b0;
      frame();
      exp_q.delete();
      frame();
      repeat (20) @(negedge clk);
      ready = 1'b1;
      repeat (8) @(negedge clk);
      `CHK(exp_q.size(), 0)
      // Gate low forces the zero code and drops input.
      gate = 1'b0;
      repeat (4) @(negedge clk);
      `CHK({da, db}, {32'hFFFF0000, 32'hFFFF0000})
      frame();
      gate = 1'b1;
      repeat (4) @(negedge clk);
      frame();
      // The strobe realigns the divider regardless of its phase.
      sync_lat(l1);
      repeat (1 + $urandom() % 3) @(negedge clk);
      sync_lat(l2);
      `CHK({l1 < 12, l1}, {1'b1, l2})
      repeat (30) @(negedge clk);
      // A mid-run reset restores the idle drive levels, then streaming resumes.
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      `CHK({da, db, valid, tick, ovf}, {32'hFFFF0000, 32'hFFFF0000, 3'h0})
      nrst = 1'b1;
      frame();
      repeat (30) @(negedge clk);
      `CHK({ovf, exp_q.size()}, 33'h0)
      final_report();
   end
endmodule

// file: dv/dfc_host_model.sv
// Host model that drives byte pairs and the frame marker toward the capture block.
module dfc_host_model
   import dfc_pkg::*;
(
   output logic             o_valid,
   output logic [BUS_W-1:0] o_rise,
   output logic [BUS_W-1:0] o_fall,
   output logic             o_marker,
   input  wire logic        i_clk
);
   timeunit 1ns;
   timeprecision 1ps;

   // Lines start idle before any pair is sent.
   initial begin
      o_valid  = 1'b0;
      o_rise   = 8'h00;
      o_fall   = 8'h00;
      o_marker = 1'b0;
   end

   // Sends one pair; the marker moves with the bytes and all hold across the sync delay.
   task automatic send_pair(input logic mk, input logic [7:0] r, input logic [7:0] f);
      @(negedge i_clk);
      {o_marker, o_rise, o_fall} = {mk, r, f};
      o_valid = 1'b1;
      @(negedge i_clk);
      o_valid = 1'b0;
      repeat (3) @(negedge i_clk);
      // Released byte lines show the inverse and the marker drops low, so stale data cannot pass for fresh data.
      {o_marker, o_rise, o_fall} = {1'b0, ~r, ~f};
      repeat (2) @(negedge i_clk);
   endtask

   // Sends one frame: A high and A low on the marked pair, then B high and B low.
   task automatic send_frame(input dfc_pair_t p);
      send_pair(1'b1, p.chan_a[15:8], p.chan_a[7:0]);
      send_pair(1'b0, p.chan_b[15:8], p.chan_b[7:0]);
   endtask
endmodule

// file: rtl/dfc_buf2.sv
// Two-entry valid/ready buffer used in the sample path.
module dfc_buf2
   import dfc_pkg::*;
#(
   parameter int unsigned WIDTH = 32
) (
   input  wire logic             i_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_flush,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   // Storage for the two entries, head in slot 0.
   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   // Number of entries held, 0 to 2.
   logic [1:0]       cnt_q;
   logic [1:0]       cnt_d;
   logic             push;
   logic             pop;

   // Handshake outputs follow the fill level directly.
   assign o_ready = (cnt_q != 2'h2);
   assign o_valid = (cnt_q != 2'h0);
   assign o_data  = mem_q[0];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   // Next-state of the entries and count; a flush empties the buffer.
   always_comb begin
      mem_d[0] = mem_q[0];
      mem_d[1] = mem_q[1];
      cnt_d    = cnt_q;
      if (pop) begin
         mem_d[0] = mem_q[1];
      end
      if (push) begin
         if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
            mem_d[0] = i_data;
         end else begin
            mem_d[1] = i_data;
         end
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
      if (i_flush) begin
         cnt_d = 2'h0;
      end
   end

   // Registers of the buffer.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_q    <= 2'h0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else begin
         cnt_q    <= cnt_d;
         mem_q[0] <= mem_d[0];
         mem_q[1] <= mem_d[1];
      end
   end

   // The count never exceeds the depth.
   chk_buf_depth_bound : assert property (@(posedge i_clk) disable iff (!i_nrst)
      cnt_q <= 2'h2)
      else $error("buffer count above two");
endmodule

// file: rtl/dfc_capture.sv
// Input capture of a dual-channel converter: DDR byte bus, frame, gate, strobe.
module dfc_capture
   import dfc_pkg::*;
#(
   parameter int unsigned DIV_W = 4
) (
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_ddr_rise_valid,
   input  wire logic [BUS_W-1:0]  i_ddr_rise_byte,
   input  wire logic [BUS_W-1:0]  i_ddr_fall_byte,
   input  wire logic              i_burst_marker,
   input  wire logic              i_transmit_gate,
   input  wire logic              i_divider_sync,
   input  wire logic              i_bus_reverse,
   input  wire logic              i_four_pin_mode,
   input  wire logic              i_reference_select,
   input  wire logic              i_serial_select_n,
   input  wire logic              i_serial_data_drive,
   input  wire logic              i_serial_data_out,
   input  wire logic              i_sink_ready,
   output logic                   o_sink_valid,
   output dfc_out_t               o_chan_a_drive,
   output dfc_out_t               o_chan_b_drive,
   output logic                   o_serial_data_o,
   output logic                   o_serial_data_oe,
   output logic                   o_serial_select_oe,
   output logic                   o_reference_out_en,
   output logic                   o_div_tick,
   output logic                   o_overflow
);
   // Reverses the bit order of one bus byte.
   function automatic logic [BUS_W-1:0] flip_byte(input logic [BUS_W-1:0] b);
      logic [BUS_W-1:0] r;
      r = '0;
      for (int i = 0; i < BUS_W; i++) begin
         r[i] = b[BUS_W-1-i];
      end
      return r;
   endfunction

   // Two-flop synchronisers for pin inputs (marker, gate, strobe, pair valid).
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   // Data bytes pass the same two stages as their valid flag.
   logic [15:0] dat1_q;
   logic [15:0] dat2_q;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         dat1_q  <= 16'h0000;
         dat2_q  <= 16'h0000;
      end else begin
         sync1_q <= {i_ddr_rise_valid, i_divider_sync, i_transmit_gate, i_burst_marker};
         sync2_q <= sync1_q;
         dat1_q  <= {i_ddr_rise_byte, i_ddr_fall_byte};
         dat2_q  <= dat1_q;
      end
   end

   logic marker_s;
   logic gate_s;
   logic strobe_s;
   logic pair_v;
   assign marker_s = sync2_q[0];
   assign gate_s   = sync2_q[1];
   assign strobe_s = sync2_q[2];
   assign pair_v   = sync2_q[3];

   // Rising and falling bytes, bit order reversed on request.
   logic [BUS_W-1:0] rise_b;
   logic [BUS_W-1:0] fall_b;
   assign rise_b = i_bus_reverse ? flip_byte(dat2_q[15:8]) : dat2_q[15:8];
   assign fall_b = i_bus_reverse ? flip_byte(dat2_q[7:0])  : dat2_q[7:0];

   // Frame assembly: each DDR cycle yields two bytes, two cycles make a frame.
   dfc_state_t  st_q;
   dfc_state_t  st_d;
   logic [15:0] hold_q;
   logic [15:0] hold_d;
   logic        pair_push;
   dfc_pair_t   pair_word;
   logic        buf_ready;
   logic        ovf_q;
   logic        ovf_d;

   // Next-state of the collector; a marker restarts on channel A.
   always_comb begin
      st_d      = st_q;
      hold_d    = hold_q;
      pair_push = 1'b0;
      pair_word = '{chan_a: hold_q, chan_b: {rise_b, fall_b}};
      ovf_d     = ovf_q;
      if (pair_v) begin
         if (marker_s) begin
            hold_d = {rise_b, fall_b};
            st_d   = ST_COLLECT;
         end else begin
            case (st_q)
               ST_COLLECT: begin
                  pair_push = gate_s;
                  st_d      = ST_HUNT;
                  if (gate_s && !buf_ready) begin
                     ovf_d = 1'b1;
                  end
               end
               default: begin
                  st_d = ST_HUNT;
               end
            endcase
         end
      end
      if (!gate_s) begin
         hold_d = SAMPLE_ZERO;
      end
   end

   // Collector registers.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_q   <= ST_HUNT;
         hold_q <= SAMPLE_ZERO;
         ovf_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         hold_q <= hold_d;
         ovf_q  <= ovf_d;
      end
   end
   assign o_overflow = ovf_q;

   // Sample buffer; a frame marker flushes it to realign the pointers.
   logic        buf_valid;
   dfc_pair_t   buf_data;
   logic        flush;
   assign flush = pair_v && marker_s;
   dfc_buf2 #(
      .WIDTH(2 * SAMPLE_W)
   ) u_buf (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_flush (flush),
      .i_valid (pair_push),
      .o_ready (buf_ready),
      .i_data  (pair_word),
      .o_valid (buf_valid),
      .i_ready (i_sink_ready),
      .o_data  (buf_data)
   );
   assign o_sink_valid = buf_valid;

   // Output drive registers: true sink falls with code, complement rises.
   dfc_out_t drv_a_q;
   dfc_out_t drv_a_d;
   dfc_out_t drv_b_q;
   dfc_out_t drv_b_d;
   always_comb begin
      drv_a_d = drv_a_q;
      drv_b_d = drv_b_q;
      if (!gate_s) begin
         drv_a_d = '{true_sink: SAMPLE_FULL, comp_sink: SAMPLE_ZERO};
         drv_b_d = '{true_sink: SAMPLE_FULL, comp_sink: SAMPLE_ZERO};
      end else if (buf_valid && i_sink_ready) begin
         drv_a_d = '{true_sink: ~buf_data.chan_a, comp_sink: buf_data.chan_a};
         drv_b_d = '{true_sink: ~buf_data.chan_b, comp_sink: buf_data.chan_b};
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         drv_a_q <= '{true_sink: SAMPLE_FULL, comp_sink: SAMPLE_ZERO};
         drv_b_q <= '{true_sink: SAMPLE_FULL, comp_sink: SAMPLE_ZERO};
      end else begin
         drv_a_q <= drv_a_d;
         drv_b_q <= drv_b_d;
      end
   end
   assign o_chan_a_drive = drv_a_q;
   assign o_chan_b_drive = drv_b_q;

   // Clock divider, reset by the strobe's rising edge.
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic             strobe_prev_q;
   logic             tick_q;
   logic             tick_d;
   always_comb begin
      tick_d = 1'b0;
      if (strobe_s && !strobe_prev_q) begin
         div_d = DIV_W'(DIV_RST);
      end else if (div_q == DIV_W'(DIV_LAST)) begin
         div_d  = DIV_W'(DIV_RST);
         tick_d = 1'b1;
      end else begin
         div_d = div_q + DIV_W'(1);
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         div_q         <= DIV_W'(DIV_RST);
         strobe_prev_q <= 1'b0;
         tick_q        <= 1'b0;
      end else begin
         div_q         <= div_d;
         strobe_prev_q <= strobe_s;
         tick_q        <= tick_d;
      end
   end
   assign o_div_tick = tick_q;

   // Pin direction controls.
   assign o_serial_data_oe   = !i_four_pin_mode && !i_serial_select_n && i_serial_data_drive;
   assign o_serial_data_o    = i_serial_data_out;
   assign o_serial_select_oe = 1'b0;
   assign o_reference_out_en = !i_reference_select;

   chk_gate_zero_out : assert property (@(posedge i_clk) disable iff (!i_nrst)
      !gate_s |=> (drv_a_q.comp_sink == SAMPLE_ZERO && drv_b_q.comp_sink == SAMPLE_ZERO))
      else $error("gate low did not zero outputs");
   chk_comp_opposite : assert property (@(posedge i_clk) disable iff (!i_nrst)
      (drv_a_q.true_sink == ~drv_a_q.comp_sink) && (drv_b_q.true_sink == ~drv_b_q.comp_sink))
      else $error("complementary output not opposite");
   chk_marker_flush : assert property (@(posedge i_clk) disable iff (!i_nrst)
      (pair_v && marker_s) |=> !o_sink_valid)
      else $error("marker did not empty buffer");
   chk_strobe_div : assert property (@(posedge i_clk) disable iff (!i_nrst)
      (strobe_s && !strobe_prev_q) |=> div_q == DIV_W'(DIV_RST))
      else $error("strobe did not reset divider");
   chk_serial_sel_in : assert property (@(posedge i_clk) !o_serial_select_oe)
      else $error("serial select driven");
   chk_four_pin_in : assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_four_pin_mode |-> !o_serial_data_oe)
      else $error("serial data driven in four-pin mode");
   chk_ref_select : assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_reference_out_en == !i_reference_select)
      else $error("reference direction wrong");
   chk_frame_pairs : assert property (@(posedge i_clk) disable iff (!i_nrst)
      (pair_v && marker_s && gate_s) |-> ##[1:2] (st_q == ST_COLLECT))
      else $error("marker did not start collection");

   // Frame completion: the collector waits for the closing pair of a frame.
   sequence seq_collecting;
      st_q == ST_COLLECT;
   endsequence
   // The closing pair is unmarked, gated open and finds room in the buffer.
   sequence seq_closing_pair;
      pair_v && !marker_s && gate_s && buf_ready;
   endsequence
   chk_frame_push : assert property (@(posedge i_clk) disable iff (!i_nrst)
      (seq_collecting ##0 seq_closing_pair) |=> o_sink_valid)
      else $error("completed frame did not reach buffer");
endmodule

// file: rtl/dfc_pkg.sv
// Package holding constants and carrier types for the DDR frame input capture block.
package dfc_pkg;
   // Width of one bus transfer (one byte).
   localparam int unsigned BUS_W         = 8;
   // Width of one converter sample.
   localparam int unsigned SAMPLE_W      = 16;
   // Bytes that make up one frame: two channels, two bytes each.
   localparam int unsigned FRAME_BYTES   = 4;
   // Reset value of the divider counter.
   localparam logic [3:0]  DIV_RST       = 4'h0;
   // Default divider terminal count (divide by 4).
   localparam logic [3:0]  DIV_LAST      = 4'h3;
   // Zero sample forced while the transmit gate is low.
   localparam logic [15:0] SAMPLE_ZERO   = 16'h0000;
   // Full-scale code of the offset-binary sample.
   localparam logic [15:0] SAMPLE_FULL   = 16'hFFFF;
   // Byte position values inside a frame.
   localparam logic [1:0]  POS_A_HI      = 2'h0;
   localparam logic [1:0]  POS_A_LO      = 2'h1;
   localparam logic [1:0]  POS_B_HI      = 2'h2;
   localparam logic [1:0]  POS_B_LO      = 2'h3;

   // One pair of samples, channel A and channel B.
   typedef struct packed {
      logic [15:0] chan_a;
      logic [15:0] chan_b;
   } dfc_pair_t;

   // Drive levels for one channel's true and complementary outputs.
   typedef struct packed {
      logic [15:0] true_sink;
      logic [15:0] comp_sink;
   } dfc_out_t;

   // Assembly states of the frame byte collector.
   typedef enum logic [1:0] {
      ST_HUNT,
      ST_COLLECT
   } dfc_state_t;
endpackage
